// ===== src/counter_ram.sv
module counter_ram #(
	parameter int W     = 8,
	parameter int DEPTH = 32,
	parameter int AW    = 5
) (
	input  wire logic          clk,
	input  wire logic          ce,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	input  wire logic [AW-1:0] raddr_a,
	output logic      [W-1:0]  rdata_a,
	input  wire logic [AW-1:0] raddr_b,
	output logic      [W-1:0]  rdata_b
);

	// ****************************************************************
	// Storage with one write port and two registered read ports.
	// ****************************************************************

	logic [W-1:0] mem [DEPTH];

	// Reads return the value held before a write in the same cycle.
	always_ff @(posedge clk) begin
		if (ce) begin
			if (we) begin
				mem[waddr] <= wdata;
			end
			rdata_a <= mem[raddr_a];
			rdata_b <= mem[raddr_b];
		end
	end

endmodule : counter_ram

// ===== src/highway_link_diag_counters.sv
// Operation
// - Count ack timeouts at index 1.
// - Count highway contention at index 2.
// - Never retry a reply hit by contention.
// - Count nonzero, non-memory-full ack status.
// - Count each message returned to sender.
// - Memory full: count, wait, retry five.
// - Poll timeout takes mastership and counts.
// - Failed handover counts, keeps polling.
// - Count status frame heard as message.
// - Reject incomplete header, count index 9.
// - Reject destination equal to source, count.
// - Ack without buffer counts, next overflows.
// - Bad CRC: message index 12, ack 0.
// - Count messages longer than 250 bytes.
// - Count message arriving without buffer.
// - Discard and count duplicates between polls.
// - 16-bit transmitted and received message counts.
// - 16-bit count of generated commands.
// - Count executed commands, one reply each.
// - 16-bit count of replies setting bits.
// - Count resyncs and terminal breaks.
// - Cable errors count down modulo five.
// - Byte counters wrap to zero.
// - Reader gets base, then reads offsets.
module highway_link_diag_counters
	import hw_diag_pkg::*;
#(
	parameter int         WAIT_CYCLES  = RETRY_WAIT_CYCLES,
	parameter logic [7:0] COUNTER_BASE = DEFAULT_BASE
) (
	input  wire logic       clk,
	input  wire logic       ce,
	input  wire logic       sys_rst,
	input  wire logic       rx_frame_valid,
	input  wire rx_frame_t  rx_frame,
	input  wire logic       poll_seen,
	input  wire logic       ack_rx_valid,
	input  wire ack_t       ack_rx,
	input  wire logic       ack_timeout,
	input  wire logic       contention,
	input  wire logic       tx_is_reply,
	input  wire logic       poll_timeout,
	input  wire logic       handover_no_response,
	input  wire logic       handover_done,
	input  wire logic       ack_sent_no_buffer,
	input  wire logic       command_generated,
	input  wire logic       abort_seen,
	input  wire logic       host_resync,
	input  wire logic       terminal_break,
	input  wire logic       cable_error,
	input  wire logic       diag_status_req,
	input  wire logic       diag_rd_req,
	input  wire logic [7:0] diag_rd_addr,
	output logic      [7:0] diag_base,
	output logic            diag_status_valid,
	output logic      [7:0] diag_rd_data,
	output logic            diag_rd_valid,
	output logic            rx_accept,
	output logic            rx_discard,
	output logic            reply_send,
	output logic            tx_retry,
	output logic            tx_return,
	output logic            reply_destroy,
	output logic            master,
	output logic            forced_io_reset
);

	// ****************************************************************
	// Helpers.
	// ****************************************************************

	// One-hot set vector for a counter index.
	function automatic logic [NUM_SLOTS-1:0] hit(input logic [IDX_W-1:0] idx);
		hit = '0;
		hit[idx] = 1'b1;
	endfunction : hit

	// Lowest pending counter index.
	function automatic logic [IDX_W-1:0] lowest(input logic [NUM_SLOTS-1:0] v);
		lowest = '0;
		for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
			if (v[i]) begin
				lowest = IDX_W'(i);
			end
		end
	endfunction : lowest

	// ****************************************************************
	// Received frame classification.
	// ****************************************************************

	logic       dup_valid;
	logic [7:0] dup_seq;
	logic       dup_cmd;
	logic       mem_ovf_armed;

	// Frames are checked in order; the first failure decides the counter.
	wire logic fr_short   = !rx_frame.header_ok;
	wire logic fr_crc     = !fr_short && !rx_frame.crc_ok;
	wire logic fr_status  = !fr_short && !fr_crc && rx_frame.is_status;
	wire logic fr_pass1   = !fr_short && !fr_crc && !rx_frame.is_status;
	wire logic fr_wdest   = fr_pass1 && !rx_frame.is_ack &&
		(rx_frame.src == rx_frame.dest);
	wire logic fr_msg     = fr_pass1 && !rx_frame.is_ack && !fr_wdest;
	wire logic fr_big     = fr_msg && (rx_frame.length > MAX_MSG_BYTES);
	wire logic fr_nobuf   = fr_msg && !fr_big &&
		(!rx_frame.buffer_ready || mem_ovf_armed);
	wire logic fr_dup     = fr_msg && !fr_big && !fr_nobuf && dup_valid &&
		(dup_seq == rx_frame.seq) && (dup_cmd == rx_frame.is_command);
	wire logic fr_good    = fr_msg && !fr_big && !fr_nobuf && !fr_dup;
	wire logic fr_exec    = fr_good && rx_frame.is_command;
	wire logic fr_reply   = fr_good && !rx_frame.is_command && rx_frame.done_or_error;
	wire logic fr_v       = rx_frame_valid;

	// Acknowledgement outcome on the transmit side.
	wire logic ack_bad_crc = ack_rx_valid && !ack_rx.crc_ok;
	wire logic ack_full    = ack_rx_valid && ack_rx.crc_ok &&
		(ack_rx.status == ACK_STATUS_MEM_FULL);
	wire logic ack_other   = ack_rx_valid && ack_rx.crc_ok &&
		(ack_rx.status != ACK_STATUS_MEM_FULL) && (ack_rx.status != ACK_STATUS_OK);
	wire logic ack_good    = ack_rx_valid && ack_rx.crc_ok && (ack_rx.status == ACK_STATUS_OK);

	// ****************************************************************
	// Memory-full retry and reply destruction.
	// ****************************************************************

	logic [2:0]  retry_cnt;
	logic [31:0] wait_cnt;
	logic        waiting;

	wire logic retry_exhausted = ack_full && (retry_cnt == MAX_RETRIES);
	wire logic reply_lost      = contention && tx_is_reply;
	wire logic wait_done       = waiting && (wait_cnt == 32'h0000_0001);

	// Holds a memory-full message for the wait time, then asks for a retry.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			retry_cnt <= 3'h0;
			waiting   <= 1'b0;
			wait_cnt  <= 32'h0000_0000;
		end else if (ce) begin
			if (ack_good || retry_exhausted) begin
				retry_cnt <= 3'h0;
				waiting   <= 1'b0;
			end else if (ack_full) begin
				retry_cnt <= retry_cnt + 3'h1;
				waiting   <= 1'b1;
				wait_cnt  <= 32'(WAIT_CYCLES);
			end else if (waiting) begin
				wait_cnt <= wait_cnt - 32'h0000_0001;
				waiting  <= !wait_done;
			end
		end
	end

	// Link driver strobes; a contended command is retried, a reply is not.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_retry      <= 1'b0;
			tx_return     <= 1'b0;
			reply_destroy <= 1'b0;
		end else if (ce) begin
			tx_retry      <= wait_done || (contention && !tx_is_reply);
			tx_return     <= retry_exhausted;
			reply_destroy <= reply_lost;
		end
	end

	// ****************************************************************
	// Mastership and receive-side state.
	// ****************************************************************

	// Poll timeout grabs the highway; a silent successor leaves us polling.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			master <= 1'b0;
		end else if (ce) begin
			if (poll_timeout || handover_no_response) begin
				master <= 1'b1;
			end else if (handover_done) begin
				master <= 1'b0;
			end
		end
	end

	// Duplicate history lives between polls; a buffer-less ack arms overflow.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dup_valid     <= 1'b0;
			dup_seq       <= 8'h00;
			dup_cmd       <= 1'b0;
			mem_ovf_armed <= 1'b0;
		end else if (ce) begin
			if (fr_v && fr_good) begin
				dup_valid <= 1'b1;
				dup_seq   <= rx_frame.seq;
				dup_cmd   <= rx_frame.is_command;
			end else if (poll_seen) begin
				dup_valid <= 1'b0;
			end
			if (ack_sent_no_buffer) begin
				mem_ovf_armed <= 1'b1;
			end else if (fr_v && fr_msg && !fr_big) begin
				mem_ovf_armed <= 1'b0;
			end
		end
	end

	// Frame verdict strobes, one reply per executed command.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_accept  <= 1'b0;
			rx_discard <= 1'b0;
			reply_send <= 1'b0;
		end else if (ce) begin
			rx_accept  <= fr_v && fr_good;
			rx_discard <= fr_v && !fr_good && !(fr_pass1 && rx_frame.is_ack);
			reply_send <= fr_v && fr_exec;
		end
	end

	// ****************************************************************
	// Event collection.
	// ****************************************************************

	wire logic [NUM_SLOTS-1:0] ev_link =
		({NUM_SLOTS{ack_timeout}} & hit(IDX_ACK_TMO)) |
		({NUM_SLOTS{contention}} & hit(IDX_CONTEND)) |
		({NUM_SLOTS{ack_other}} & hit(IDX_BAD_ACK)) |
		({NUM_SLOTS{retry_exhausted || reply_lost}} & hit(IDX_RETURNED)) |
		({NUM_SLOTS{ack_full}} & hit(IDX_TX_MFULL)) |
		({NUM_SLOTS{poll_timeout}} & hit(IDX_POLL_TMO)) |
		({NUM_SLOTS{handover_no_response}} & hit(IDX_FALSE_PL)) |
		({NUM_SLOTS{ack_sent_no_buffer}} & hit(IDX_RX_MFULL)) |
		({NUM_SLOTS{ack_bad_crc}} & hit(IDX_ACK_CRC)) |
		({NUM_SLOTS{ack_good}} & hit(IDX_TX_MSG)) |
		({NUM_SLOTS{command_generated}} & hit(IDX_CMD_SENT)) |
		({NUM_SLOTS{abort_seen}} & hit(IDX_ABORT)) |
		({NUM_SLOTS{reply_lost}} & hit(IDX_UNDELIV));

	wire logic [NUM_SLOTS-1:0] ev_rx = {NUM_SLOTS{fr_v}} & (
		({NUM_SLOTS{fr_short}} & hit(IDX_SHORT)) |
		({NUM_SLOTS{fr_crc && !rx_frame.is_ack}} & hit(IDX_BAD_CRC)) |
		({NUM_SLOTS{fr_crc && rx_frame.is_ack}} & hit(IDX_ACK_CRC)) |
		({NUM_SLOTS{fr_status}} & hit(IDX_HEARD_ST)) |
		({NUM_SLOTS{fr_wdest}} & hit(IDX_WRONG_DST)) |
		({NUM_SLOTS{fr_big}} & hit(IDX_BUF_OVF)) |
		({NUM_SLOTS{fr_nobuf}} & hit(IDX_MEM_OVF)) |
		({NUM_SLOTS{fr_dup}} & hit(IDX_DUPLICATE)) |
		({NUM_SLOTS{fr_good}} & hit(IDX_RX_MSG)) |
		({NUM_SLOTS{fr_exec}} & hit(IDX_CMD_EXEC)) |
		({NUM_SLOTS{fr_reply}} & hit(IDX_REPLY_RX)));

	wire logic [NUM_SLOTS-1:0] ev_host =
		({NUM_SLOTS{host_resync}} & hit(IDX_RESYNC)) |
		({NUM_SLOTS{terminal_break}} & hit(IDX_BREAK)) |
		({NUM_SLOTS{cable_error}} & hit(IDX_CABLE));

	// ****************************************************************
	// Counter update engine.
	// ****************************************************************

	typedef enum logic [2:0] {S_CLEAR, S_IDLE, S_ISSUE, S_LO, S_HI} scan_state_t;

	scan_state_t           state;
	logic [NUM_SLOTS-1:0]  pending;
	logic [IDX_W-1:0]      cur_idx;
	logic [7:0]            rd_lo;
	logic [7:0]            rd_b;

	wire logic [NUM_SLOTS-1:0] events   = ev_link | ev_rx | ev_host;
	wire logic                 pick     = (state == S_IDLE) && (pending != '0);
	wire logic [IDX_W-1:0]     pick_idx = lowest(pending);
	wire logic [NUM_SLOTS-1:0] clr      = pick ? hit(pick_idx) : '0;
	wire logic [NUM_SLOTS-1:0] next_pending = (pending & ~clr) | events;
	wire logic                 is_wide  = WIDE_MASK[cur_idx];
	wire logic                 is_cable = (cur_idx == IDX_CABLE);
	wire logic [7:0]           next_lo  = is_cable ?
		((rd_lo == COUNTER_RESET) ? CABLE_MOD_TOP : rd_lo - 8'h01) : rd_lo + 8'h01;
	wire logic                 carry    = is_wide && (rd_lo == 8'hFF);
	wire logic [IDX_W-1:0]     hi_idx   = cur_idx + IDX_W'(1);
	wire logic [IDX_W-1:0]     rd_a_idx = (state == S_LO) ? hi_idx : cur_idx;
	wire logic                 mem_we   = (state == S_CLEAR) || (state == S_LO) ||
		(state == S_HI);
	wire logic [IDX_W-1:0]     mem_wa   = (state == S_HI) ? hi_idx : cur_idx;
	wire logic [7:0]           mem_wd   = (state == S_CLEAR) ? COUNTER_RESET :
		(state == S_LO) ? next_lo : rd_lo + 8'h01;

	// Pending flags: a new event wins over the clear of the same flag.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pending <= hit(IDX_RESYNC);
		end else if (ce) begin
			pending <= next_pending;
		end
	end

	// Sweeps the block to zero after reset, then read-modify-writes counters.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state   <= S_CLEAR;
			cur_idx <= '0;
		end else if (ce) begin
			case (state)
				S_CLEAR: begin
					cur_idx <= cur_idx + IDX_W'(1);
					if (cur_idx == IDX_W'(NUM_SLOTS - 1)) begin
						state <= S_IDLE;
					end
				end
				S_IDLE: begin
					if (pick) begin
						cur_idx <= pick_idx;
						state   <= S_ISSUE;
					end
				end
				S_ISSUE: state <= S_LO;
				S_LO:    state <= carry ? S_HI : S_IDLE;
				S_HI:    state <= S_IDLE;
				default: state <= S_IDLE;
			endcase
		end
	end

	// Cable error counter reaching zero triggers the forced-table handshake.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			forced_io_reset <= 1'b0;
		end else if (ce) begin
			forced_io_reset <= (state == S_LO) && is_cable &&
				(next_lo == COUNTER_RESET);
		end
	end

	// ****************************************************************
	// Diagnostic status and read port.
	// ****************************************************************

	logic             rd_pend;
	logic             rd_in_range;

	wire logic [7:0]       rd_off   = diag_rd_addr - COUNTER_BASE;
	wire logic             rd_legal = (rd_off < 8'(NUM_COUNTERS));
	wire logic [IDX_W-1:0] rd_idx   = rd_off[IDX_W-1:0];

	// Port b follows the request address, so its byte is ready one cycle later.
	counter_ram #(
		.W     (8),
		.DEPTH (NUM_SLOTS),
		.AW    (IDX_W)
	) u_ram (
		.clk     (clk),
		.ce      (ce),
		.we      (mem_we),
		.waddr   (mem_wa),
		.wdata   (mem_wd),
		.raddr_a (rd_a_idx),
		.rdata_a (rd_lo),
		.raddr_b (rd_idx),
		.rdata_b (rd_b)
	);

	// Status answers with the block base; reads return base-relative bytes.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			diag_base         <= 8'h00;
			diag_status_valid <= 1'b0;
			rd_pend           <= 1'b0;
			rd_in_range       <= 1'b0;
			diag_rd_data      <= 8'h00;
			diag_rd_valid     <= 1'b0;
		end else if (ce) begin
			diag_status_valid <= diag_status_req;
			if (diag_status_req) begin
				diag_base <= COUNTER_BASE;
			end
			rd_pend     <= diag_rd_req;
			rd_in_range <= diag_rd_req && rd_legal;
			diag_rd_valid <= rd_pend;
			if (rd_pend) begin
				diag_rd_data <= rd_in_range ? rd_b : 8'h00;
			end
		end
	end

endmodule : highway_link_diag_counters

// ===== src/hw_diag_pkg.sv
package hw_diag_pkg;

	// ****************************************************************
	// Counter block layout.
	// ****************************************************************

	localparam int          NUM_SLOTS     = 32;
	localparam int          IDX_W         = 5;
	localparam int          NUM_COUNTERS  = 31;
	localparam logic [4:0]  IDX_ACK_CRC   = 5'h00;
	localparam logic [4:0]  IDX_ACK_TMO   = 5'h01;
	localparam logic [4:0]  IDX_CONTEND   = 5'h02;
	localparam logic [4:0]  IDX_BAD_ACK   = 5'h03;
	localparam logic [4:0]  IDX_RETURNED  = 5'h04;
	localparam logic [4:0]  IDX_TX_MFULL  = 5'h05;
	localparam logic [4:0]  IDX_POLL_TMO  = 5'h06;
	localparam logic [4:0]  IDX_FALSE_PL  = 5'h07;
	localparam logic [4:0]  IDX_HEARD_ST  = 5'h08;
	localparam logic [4:0]  IDX_SHORT     = 5'h09;
	localparam logic [4:0]  IDX_WRONG_DST = 5'h0A;
	localparam logic [4:0]  IDX_RX_MFULL  = 5'h0B;
	localparam logic [4:0]  IDX_BAD_CRC   = 5'h0C;
	localparam logic [4:0]  IDX_BUF_OVF   = 5'h0D;
	localparam logic [4:0]  IDX_MEM_OVF   = 5'h0E;
	localparam logic [4:0]  IDX_DUPLICATE = 5'h0F;
	localparam logic [4:0]  IDX_ABORT     = 5'h10;
	localparam logic [4:0]  IDX_TX_MSG    = 5'h11;
	localparam logic [4:0]  IDX_RX_MSG    = 5'h13;
	localparam logic [4:0]  IDX_CMD_SENT  = 5'h15;
	localparam logic [4:0]  IDX_CMD_EXEC  = 5'h17;
	localparam logic [4:0]  IDX_REPLY_RX  = 5'h19;
	localparam logic [4:0]  IDX_BREAK     = 5'h1B;
	localparam logic [4:0]  IDX_RESYNC    = 5'h1C;
	localparam logic [4:0]  IDX_CABLE     = 5'h1D;
	localparam logic [4:0]  IDX_UNDELIV   = 5'h1E;
	localparam logic [31:0] WIDE_MASK     = 32'h02AA_0000;
	localparam logic [7:0]  COUNTER_RESET = 8'h00;
	localparam logic [7:0]  DEFAULT_BASE  = 8'h00;

	// ****************************************************************
	// Protocol figures.
	// ****************************************************************

	localparam logic [7:0]  ACK_STATUS_OK       = 8'h00;
	localparam logic [7:0]  ACK_STATUS_MEM_FULL = 8'h01;
	localparam logic [2:0]  MAX_RETRIES         = 3'h5;
	localparam logic [8:0]  MAX_MSG_BYTES       = 9'h0FA;
	localparam logic [7:0]  CABLE_MOD_TOP       = 8'h04;
	localparam int          CLK_PERIOD_NS       = 4;
	localparam int          RETRY_WAIT_NS       = 500_000_000;
	localparam int          RETRY_WAIT_CYCLES   =
		(RETRY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ****************************************************************
	// Carriers.
	// ****************************************************************

	typedef struct packed {
		logic       header_ok;
		logic       crc_ok;
		logic       is_ack;
		logic       is_status;
		logic       is_command;
		logic       done_or_error;
		logic       buffer_ready;
		logic [7:0] src;
		logic [7:0] dest;
		logic [7:0] seq;
		logic [8:0] length;
	} rx_frame_t;

	typedef struct packed {
		logic       crc_ok;
		logic [7:0] status;
	} ack_t;

endpackage : hw_diag_pkg

// ===== tb/diag_counters_props.sv
module diag_counters_props
	import hw_diag_pkg::*;
#(
	parameter logic [7:0] COUNTER_BASE = DEFAULT_BASE
) (
	input wire logic       clk,
	input wire logic       sys_rst,
	input wire logic       rx_frame_valid,
	input wire rx_frame_t  rx_frame,
	input wire logic       contention,
	input wire logic       tx_is_reply,
	input wire logic       poll_timeout,
	input wire logic       handover_no_response,
	input wire logic       handover_done,
	input wire logic       diag_status_req,
	input wire logic       diag_rd_req,
	input wire logic [7:0] diag_base,
	input wire logic       diag_status_valid,
	input wire logic       diag_rd_valid,
	input wire logic       rx_accept,
	input wire logic       rx_discard,
	input wire logic       reply_send,
	input wire logic       tx_retry,
	input wire logic       reply_destroy,
	input wire logic       master
);
	timeunit 1ns;
	timeprecision 1ps;

	// ********
	// Checks
	// ********

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// A frame that passes every header test but names itself as source.
	wire self_frame = rx_frame_valid && rx_frame.header_ok && rx_frame.crc_ok &&
		!rx_frame.is_status && !rx_frame.is_ack && rx_frame.src == rx_frame.dest;

	status_answer_a: assert property (diag_status_req |=> diag_status_valid &&
		diag_base == COUNTER_BASE) else $error("status answer wrong");
	read_answer_a: assert property (diag_rd_req |-> ##2 diag_rd_valid)
		else $error("read answer late");
	read_unasked_a: assert property (diag_rd_valid |-> $past(diag_rd_req, 2))
		else $error("read answer without request");
	reply_no_retry_a: assert property (contention && tx_is_reply |=>
		reply_destroy && !tx_retry) else $error("reply retried");
	msg_retry_a: assert property (contention && !tx_is_reply |=> tx_retry &&
		!reply_destroy) else $error("message not retried");
	poll_master_a: assert property (poll_timeout |=> master)
		else $error("no mastership on poll timeout");
	false_poll_a: assert property (handover_no_response && !handover_done |=>
		master) else $error("polling not resumed");
	short_reject_a: assert property (rx_frame_valid && !rx_frame.header_ok |=>
		rx_discard && !rx_accept && !reply_send) else $error("short frame kept");
	self_reject_a: assert property (self_frame |=> rx_discard && !rx_accept)
		else $error("self addressed frame kept");
	reply_pair_a: assert property (reply_send |-> rx_accept &&
		$past(rx_frame_valid && rx_frame.is_command)) else $error("stray reply");

	// Main scenarios.
	cover property (diag_status_req ##1 diag_status_valid);
	cover property (reply_destroy);
	cover property (reply_send);
endmodule : diag_counters_props

bind highway_link_diag_counters diag_counters_props #(.COUNTER_BASE(COUNTER_BASE)) u_props (
	.clk, .sys_rst, .rx_frame_valid, .rx_frame, .contention, .tx_is_reply,
	.poll_timeout, .handover_no_response, .handover_done, .diag_status_req,
	.diag_rd_req, .diag_base, .diag_status_valid, .diag_rd_valid, .rx_accept,
	.rx_discard, .reply_send, .tx_retry, .reply_destroy, .master);

// ===== tb/highway_station_model.sv
module highway_station_model
	import hw_diag_pkg::*;
(
	input wire logic clk,
	input wire logic tx_retry,
	output logic      rx_frame_valid,
	output rx_frame_t rx_frame,
	output logic      poll_seen,
	output logic      ack_rx_valid,
	output ack_t      ack_rx
);
	timeunit 1ns;
	timeprecision 1ps;

	rx_frame_t fq = '0;
	ack_t      aq = '0;
	bit        fgo = 1'b0;
	bit        ago = 1'b0;
	bit        pgo = 1'b0;
	int        mf_left = 0;

	// Far station answers each retry with memory full while it still has retries to refuse.
	always @(posedge clk) begin
		rx_frame_valid <= fgo;
		rx_frame       <= fq;
		poll_seen      <= pgo;
		ack_rx_valid   <= ago || (tx_retry && mf_left > 0);
		ack_rx         <= aq;
		if (tx_retry && mf_left > 0) begin
			mf_left = mf_left - 1;
		end
		fgo = 1'b0;
		pgo = 1'b0;
		ago = 1'b0;
	end

	// Requests are posted off the edge so the emitter never races them.
	task frame(input rx_frame_t f);
		#1 fq = f;
		fgo = 1'b1;
		repeat (20) @(posedge clk);
	endtask : frame

	task poll();
		#1 pgo = 1'b1;
		repeat (5) @(posedge clk);
	endtask : poll

	task ack(input ack_t a, input int n);
		#1 aq = a;
		ago = 1'b1;
		mf_left = n;
		repeat (20) @(posedge clk);
	endtask : ack
endmodule : highway_station_model

// ===== tb/tb_highway_link_diag_counters.sv
module tb_highway_link_diag_counters
	import hw_diag_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [7:0] BASE = 8'h20;
	typedef struct packed {
		logic [3:0] ev;
		logic [7:0] idx;
		logic [7:0] exp;
	} row_t;
	localparam row_t ROWS [10] = '{'{4'h0, 8'h01, 8'h01}, '{4'h1, 8'h02, 8'h01},
		'{4'h2, 8'h06, 8'h01}, '{4'h3, 8'h07, 8'h01}, '{4'h4, 8'h0B, 8'h01},
		'{4'h5, 8'h15, 8'h01}, '{4'h6, 8'h10, 8'h01}, '{4'h7, 8'h1C, 8'h02},
		'{4'h8, 8'h1B, 8'h01}, '{4'h9, 8'h1D, 8'h04}};
	localparam rx_frame_t FR [11] = '{{7'h21, 8'h01, 8'h02, 8'h00, 9'h010},
		{7'h41, 8'h01, 8'h02, 8'h00, 9'h010}, {7'h51, 8'h01, 8'h02, 8'h00, 9'h010},
		{7'h69, 8'h01, 8'h02, 8'h00, 9'h010}, {7'h61, 8'h03, 8'h03, 8'h00, 9'h010},
		{7'h61, 8'h01, 8'h02, 8'h00, 9'h0FB}, {7'h61, 8'h01, 8'h02, 8'h00, 9'h010},
		{7'h65, 8'h01, 8'h02, 8'h01, 9'h0FA}, {7'h65, 8'h01, 8'h02, 8'h01, 9'h0FA},
		{7'h65, 8'h01, 8'h02, 8'h01, 9'h0FA}, {7'h63, 8'h01, 8'h02, 8'h02, 9'h010}};

	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic tx_is_reply = 1'b0;
	logic diag_status_req = 1'b0;
	logic diag_rd_req = 1'b0;
	logic [7:0] diag_rd_addr = 8'h00;
	logic [10:0] ev = 11'h000;
	logic [7:0] diag_base, diag_rd_data, rd_v;
	logic diag_status_valid, diag_rd_valid, rx_accept, rx_discard, reply_send;
	logic tx_retry, tx_return, reply_destroy, master, forced_io_reset;
	logic rx_frame_valid, poll_seen, ack_rx_valid;
	rx_frame_t rx_frame;
	ack_t ack_rx;
	logic [7:0] acc_n = 8'h00, rep_n = 8'h00, ret_n = 8'h00;
	logic [7:0] rtn_n = 8'h00, des_n = 8'h00, fio_n = 8'h00, dis_n = 8'h00;
	int bad_count = 0;
	int check_count = 0;

	// Clock at 250 MHz.
	always #2 clk = ~clk;

	// Pulses seen on the side-effect outputs are tallied once reset has let go.
	always @(posedge clk) begin
		if (!sys_rst) begin
			acc_n <= acc_n + rx_accept;
			rep_n <= rep_n + reply_send;
			ret_n <= ret_n + tx_retry;
			rtn_n <= rtn_n + tx_return;
			des_n <= des_n + reply_destroy;
			fio_n <= fio_n + forced_io_reset;
			dis_n <= dis_n + rx_discard;
		end
	end

	highway_link_diag_counters #(.WAIT_CYCLES(20), .COUNTER_BASE(BASE)) u_highway_link_diag_counters (
		.clk, .ce(1'b1), .sys_rst, .rx_frame_valid, .rx_frame, .poll_seen,
		.ack_rx_valid, .ack_rx, .ack_timeout(ev[0]), .contention(ev[1]), .tx_is_reply,
		.poll_timeout(ev[2]), .handover_no_response(ev[3]), .ack_sent_no_buffer(ev[4]),
		.command_generated(ev[5]), .abort_seen(ev[6]), .host_resync(ev[7]),
		.terminal_break(ev[8]), .cable_error(ev[9]), .handover_done(ev[10]),
		.diag_status_req, .diag_rd_req, .diag_rd_addr, .diag_base, .diag_status_valid,
		.diag_rd_data, .diag_rd_valid, .rx_accept, .rx_discard, .reply_send, .tx_retry,
		.tx_return, .reply_destroy, .master, .forced_io_reset);

	highway_station_model u_highway_station_model (.clk, .tx_retry, .rx_frame_valid,
		.rx_frame, .poll_seen, .ack_rx_valid, .ack_rx);

	// ********
	// Tasks
	// ********

	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task rd(input logic [7:0] i);
		@(posedge clk);
		diag_rd_req  <= 1'b1;
		diag_rd_addr <= BASE + i;
		@(posedge clk);
		diag_rd_req <= 1'b0;
		repeat (2) @(posedge clk);
		#1 rd_v = diag_rd_data;
	endtask : rd

	task rc(input logic [7:0] i, input logic [7:0] e);
		rd(i);
		chk($sformatf("count %h", i), {8'h00, rd_v}, {8'h00, e});
	endtask : rc

	task pulse(input int b);
		@(posedge clk);
		ev <= 11'h001 << b;
		@(posedge clk);
		ev <= 11'h000;
		repeat (12) @(posedge clk);
	endtask : pulse

	task end_of_test();
		if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	// Watchdog cuts a hang short.
	initial begin
		#40000;
		bad_count++;
		end_of_test();
	end

	// ********
	// Sequence
	// ********

	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (50) @(posedge clk);
		for (int i = 0; i < 32; i++) begin
			rc(i, (i == 28) ? 8'h01 : 8'h00);
		end
		@(posedge clk);
		diag_status_req <= 1'b1;
		@(posedge clk);
		diag_status_req <= 1'b0;
		#1 chk("status", {diag_status_valid, diag_base}, {1'b1, BASE});
		for (int r = 0; r < 10; r++) begin
			pulse(ROWS[r].ev);
			rc(ROWS[r].idx, ROWS[r].exp);
		end
		chk("master", master, 1'b1);
		for (int f = 0; f < 11; f++) begin
			if (f == 9) u_highway_station_model.poll();
			u_highway_station_model.frame(FR[f]);
		end
		u_highway_station_model.ack({1'b1, ACK_STATUS_OK}, 0);
		u_highway_station_model.ack({1'b0, ACK_STATUS_OK}, 0);
		u_highway_station_model.ack({1'b1, 8'h02}, 0);
		u_highway_station_model.ack({1'b1, ACK_STATUS_MEM_FULL}, 5);
		repeat (200) @(posedge clk);
		tx_is_reply <= 1'b1;
		pulse(1);
		tx_is_reply <= 1'b0;
		repeat (4) pulse(9);
		pulse(10);
		rc(8'h09, 8'h01);
		rc(8'h0C, 8'h01);
		rc(8'h00, 8'h02);
		rc(8'h08, 8'h01);
		rc(8'h0A, 8'h01);
		rc(8'h0D, 8'h01);
		rc(8'h0E, 8'h01);
		rc(8'h0F, 8'h01);
		rc(8'h13, 8'h03);
		rc(8'h14, 8'h00);
		rc(8'h17, 8'h02);
		rc(8'h19, 8'h01);
		rc(8'h11, 8'h01);
		rc(8'h03, 8'h01);
		rc(8'h05, 8'h06);
		rc(8'h04, 8'h02);
		rc(8'h02, 8'h02);
		rc(8'h1E, 8'h01);
		rc(8'h1D, 8'h00);
		chk("accepts", acc_n, 8'h03);
		chk("discards", dis_n, 8'h08);
		chk("replies", rep_n, 8'h02);
		chk("retries", ret_n, 8'h06);
		chk("returns", rtn_n, 8'h01);
		chk("destroys", des_n, 8'h01);
		chk("io resets", fio_n, 8'h01);
		chk("master", master, 1'b0);
		end_of_test();
	end
endmodule : tb_highway_link_diag_counters
